//--- core/hoist_brake_signal_control.sv
// Function
// RQ1 - Release brake when current, frequency or torque exceeds level for release delay.
// RQ2 - Current release level settable 0 to 300 percent of rated current.
// RQ3 - Frequency release level 0.0 to 25.0 Hz, used only under V/f control.
// RQ4 - Release delay settable 0.0 to 5.0 seconds of continuous excess.
// RQ5 - Torque release level 0 to 300 percent, used only under vector control.
// RQ6 - Terminal whose function select is 57 carries the brake command.
// RQ7 - Rated current for scaling follows heavy, medium or light duty mode.
// RQ8 - V/f: apply brake when run off and frequency below apply level for delay.
// RQ9 - Vector: apply brake when chosen speed below stop frequency for apply delay.
// RQ10 - Alarm or coast-to-stop applies the brake at once, without delay.
// RQ11 - Sequencing only for first motor; other motors hold the output on.
// RQ12 - Release timer restarts whenever no enabled level is exceeded.
//
// Implementation choices: the register addresses and register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
module hoist_brake_signal_control #(
  parameter int unsigned TICK_CYCLES = brake_pkg::TICK_CYCLES,
  parameter int unsigned N_TERM      = 6,
  parameter logic [15:0] RATED_HD    = 16'h0064,
  parameter logic [15:0] RATED_MD    = 16'h0078,
  parameter logic [15:0] RATED_LD    = 16'h0096
) (
  // Clock and reset
  input  wire logic                           hclk,
  input  wire logic                           hresetn,
  // AHB-Lite slave
  input  wire logic                           hsel,
  input  wire logic [31:0]                    haddr,
  input  wire logic [1:0]                     htrans,
  input  wire logic                           hwrite,
  input  wire logic [2:0]                     hsize,
  input  wire logic [31:0]                    hwdata,
  input  wire logic                           hready,
  output logic                                hreadyout,
  output logic                                hresp,
  output logic [31:0]                         hrdata,
  // Drive quantities, 0.1 A, 0.1 Hz and percent
  input  wire logic [brake_pkg::QTY_W-1:0]    output_current,
  input  wire logic [brake_pkg::QTY_W-1:0]    output_freq,
  input  wire logic [brake_pkg::QTY_W-1:0]    torque_cmd,
  input  wire logic [brake_pkg::QTY_W-1:0]    ref_speed,
  input  wire logic [brake_pkg::QTY_W-1:0]    det_speed,
  // Drive commands
  input  wire logic                           run_cmd,
  input  wire logic                           alarm_stop,
  input  wire logic                           coast_stop_cmd,
  // Brake command and output terminals
  output logic                                brake_release_out,
  output logic [N_TERM-1:0]                   terminal_out
);

  if (N_TERM < 1 || N_TERM > 8) begin : g_chk
    $error("N_TERM must be 1 to 8");
  end

  localparam int unsigned DW = brake_pkg::DLY_W;

  // Register state
  logic [brake_pkg::CTRL_W-1:0] ctrl_r,     ctrl_nxt;
  logic [brake_pkg::PCT_W-1:0]  rel_cur_r,  rel_cur_nxt;
  logic [brake_pkg::FRQ_W-1:0]  rel_frq_r,  rel_frq_nxt;
  logic [DW-1:0]                rel_dly_r,  rel_dly_nxt;
  logic [brake_pkg::PCT_W-1:0]  rel_trq_r,  rel_trq_nxt;
  logic [brake_pkg::FRQ_W-1:0]  app_frq_r,  app_frq_nxt;
  logic [DW-1:0]                app_dly_r,  app_dly_nxt;
  logic [brake_pkg::QTY_W-1:0]  stop_frq_r, stop_frq_nxt;
  logic [brake_pkg::SEL_W-1:0]  tsel_r   [N_TERM];
  logic [brake_pkg::SEL_W-1:0]  tsel_nxt [N_TERM];

  // Bus state
  logic                         wr_pend_r,  wr_pend_nxt;
  logic [7:0]                   wr_addr_r,  wr_addr_nxt;
  logic [31:0]                  rdata_r,    rdata_nxt;

  // Brake sequencing state
  brake_pkg::brake_state_t      st_r,       st_nxt;
  logic                         brk_r,      brk_nxt;
  logic [N_TERM-1:0]            term_r,     term_nxt;

  logic                         addr_phase;
  logic                         vec_mode;
  logic                         first_motor;
  logic                         trip;
  logic [15:0]                  rated_sel;
  logic                         cur_exceed;
  logic                         frq_exceed;
  logic                         trq_exceed;
  logic                         any_exceed;
  logic                         apply_cond;
  logic [brake_pkg::QTY_W-1:0]  speed_sel;

  delay_if #(.DW(DW)) rel_if ();
  delay_if #(.DW(DW)) app_if ();

  // Saturating write of a limited setting
  function automatic logic [15:0] clamp(input logic [31:0] v, input logic [15:0] lim);
    clamp = (v > 32'(lim)) ? lim : v[15:0];
  endfunction

  function automatic logic [31:0] tsel_word(input logic [7:0] ofs,
                                            input logic [brake_pkg::SEL_W-1:0] s [N_TERM]);
    tsel_word = '0;
    for (int i = 0; i < N_TERM; i++) begin
      if ((ofs == brake_pkg::TSEL0_OFS && i < 4) || (ofs == brake_pkg::TSEL1_OFS && i >= 4)) begin
        tsel_word[(i % 4) * 8 +: 8] = s[i];
      end
    end
  endfunction

  assign addr_phase = hsel && hready && htrans[1];

  // AHB-Lite: no wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = rdata_r;

  // Register next values; writes land in the data phase
  always_comb begin
    ctrl_nxt     = ctrl_r;
    rel_cur_nxt  = rel_cur_r;
    rel_frq_nxt  = rel_frq_r;
    rel_dly_nxt  = rel_dly_r;
    rel_trq_nxt  = rel_trq_r;
    app_frq_nxt  = app_frq_r;
    app_dly_nxt  = app_dly_r;
    stop_frq_nxt = stop_frq_r;
    tsel_nxt     = tsel_r;
    if (wr_pend_r) begin
      unique case (wr_addr_r)
        brake_pkg::CTRL_OFS:     ctrl_nxt = hwdata[brake_pkg::CTRL_W-1:0];
        // RQ2 current level range
        brake_pkg::REL_CUR_OFS:  rel_cur_nxt = brake_pkg::PCT_W'(clamp(hwdata, 16'(brake_pkg::PCT_MAX)));
        // RQ3 frequency level range
        brake_pkg::REL_FRQ_OFS:  rel_frq_nxt = brake_pkg::FRQ_W'(clamp(hwdata, 16'(brake_pkg::FRQ_MAX)));
        // RQ4 release delay range
        brake_pkg::REL_DLY_OFS:  rel_dly_nxt = DW'(clamp(hwdata, 16'(brake_pkg::DLY_MAX)));
        // RQ5 torque level range
        brake_pkg::REL_TRQ_OFS:  rel_trq_nxt = brake_pkg::PCT_W'(clamp(hwdata, 16'(brake_pkg::PCT_MAX)));
        brake_pkg::APP_FRQ_OFS:  app_frq_nxt = brake_pkg::FRQ_W'(clamp(hwdata, 16'(brake_pkg::FRQ_MAX)));
        brake_pkg::APP_DLY_OFS:  app_dly_nxt = DW'(clamp(hwdata, 16'(brake_pkg::DLY_MAX)));
        brake_pkg::STOP_FRQ_OFS: stop_frq_nxt = hwdata[brake_pkg::QTY_W-1:0];
        brake_pkg::TSEL0_OFS,
        brake_pkg::TSEL1_OFS: begin
          for (int i = 0; i < N_TERM; i++) begin
            if ((wr_addr_r == brake_pkg::TSEL0_OFS && i < 4) ||
                (wr_addr_r == brake_pkg::TSEL1_OFS && i >= 4)) begin
              tsel_nxt[i] = hwdata[(i % 4) * 8 +: 8];
            end
          end
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_r     <= brake_pkg::CTRL_W'(brake_pkg::CTRL_RST);
      rel_cur_r  <= brake_pkg::PCT_W'(brake_pkg::LVL_RST);
      rel_frq_r  <= brake_pkg::FRQ_W'(brake_pkg::LVL_RST);
      rel_dly_r  <= DW'(brake_pkg::LVL_RST);
      rel_trq_r  <= brake_pkg::PCT_W'(brake_pkg::LVL_RST);
      app_frq_r  <= brake_pkg::FRQ_W'(brake_pkg::LVL_RST);
      app_dly_r  <= DW'(brake_pkg::LVL_RST);
      stop_frq_r <= brake_pkg::QTY_W'(brake_pkg::LVL_RST);
      for (int i = 0; i < N_TERM; i++) begin
        tsel_r[i] <= brake_pkg::SEL_W'(brake_pkg::TSEL_RST);
      end
    end else begin
      ctrl_r     <= ctrl_nxt;
      rel_cur_r  <= rel_cur_nxt;
      rel_frq_r  <= rel_frq_nxt;
      rel_dly_r  <= rel_dly_nxt;
      rel_trq_r  <= rel_trq_nxt;
      app_frq_r  <= app_frq_nxt;
      app_dly_r  <= app_dly_nxt;
      stop_frq_r <= stop_frq_nxt;
      tsel_r     <= tsel_nxt;
    end
  end

  // Bus phase tracking; reads mux the next values so a read right after a
  // write to the same register already sees the new data
  always_comb begin
    wr_pend_nxt = addr_phase && hwrite;
    wr_addr_nxt = addr_phase ? haddr[7:0] : wr_addr_r;
    rdata_nxt   = rdata_r;
    if (addr_phase && !hwrite) begin
      unique case (haddr[7:0])
        brake_pkg::CTRL_OFS:     rdata_nxt = 32'(ctrl_nxt);
        brake_pkg::REL_CUR_OFS:  rdata_nxt = 32'(rel_cur_nxt);
        brake_pkg::REL_FRQ_OFS:  rdata_nxt = 32'(rel_frq_nxt);
        brake_pkg::REL_DLY_OFS:  rdata_nxt = 32'(rel_dly_nxt);
        brake_pkg::REL_TRQ_OFS:  rdata_nxt = 32'(rel_trq_nxt);
        brake_pkg::APP_FRQ_OFS:  rdata_nxt = 32'(app_frq_nxt);
        brake_pkg::APP_DLY_OFS:  rdata_nxt = 32'(app_dly_nxt);
        brake_pkg::STOP_FRQ_OFS: rdata_nxt = 32'(stop_frq_nxt);
        brake_pkg::TSEL0_OFS,
        brake_pkg::TSEL1_OFS:    rdata_nxt = tsel_word(haddr[7:0], tsel_nxt);
        brake_pkg::STATUS_OFS:   rdata_nxt = {27'h000_0000, app_if.running, rel_if.running, st_r, brk_r};
        default:                 rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
      rdata_r   <= 32'h0000_0000;
    end else begin
      wr_pend_r <= wr_pend_nxt;
      wr_addr_r <= wr_addr_nxt;
      rdata_r   <= rdata_nxt;
    end
  end

  assign vec_mode    = ctrl_r[brake_pkg::CTRL_VEC_BIT];
  assign first_motor = (ctrl_r[brake_pkg::CTRL_MOT_LSB +: 2] == brake_pkg::MOTOR_FIRST);
  assign trip        = alarm_stop || coast_stop_cmd;

  // RQ7 duty-mode rated current
  always_comb begin
    unique case (ctrl_r[brake_pkg::CTRL_DUTY_LSB +: 2])
      brake_pkg::DUTY_MEDIUM: rated_sel = RATED_MD;
      brake_pkg::DUTY_LIGHT:  rated_sel = RATED_LD;
      default:                rated_sel = RATED_HD;
    endcase
  end

  // RQ2 percent of rated current
  assign cur_exceed = (32'(output_current) * 32'(brake_pkg::PCT_FULL)) > (32'(rel_cur_r) * 32'(rated_sel));
  // RQ3 only under V/f
  assign frq_exceed = !vec_mode && (output_freq > 16'(rel_frq_r));
  // RQ5 only under vector
  assign trq_exceed = vec_mode && (torque_cmd > 16'(rel_trq_r));
  assign any_exceed = cur_exceed || frq_exceed || trq_exceed;

  // RQ9 speed source choice
  assign speed_sel  = ctrl_r[brake_pkg::CTRL_SPD_BIT] ? ref_speed : det_speed;
  // RQ8 V/f and RQ9 vector apply condition
  assign apply_cond = vec_mode ? (speed_sel < stop_frq_r) : (!run_cmd && (output_freq < 16'(app_frq_r)));

  // RQ12 timer clears when nothing exceeds
  assign rel_if.cond  = (st_r == brake_pkg::BRK_APPLIED) && any_exceed && !trip && first_motor;
  assign rel_if.delay = rel_dly_r;
  assign app_if.cond  = (st_r == brake_pkg::BRK_RELEASED) && apply_cond && !trip && first_motor;
  assign app_if.delay = app_dly_r;

  // RQ4 release delay timing
  delay_timer #(.TICK_CYCLES(TICK_CYCLES), .DW(DW)) u_rel_timer (
    .hclk    (hclk),
    .hresetn (hresetn),
    .dif     (rel_if)
  );

  // RQ9 apply delay timing
  delay_timer #(.TICK_CYCLES(TICK_CYCLES), .DW(DW)) u_app_timer (
    .hclk    (hclk),
    .hresetn (hresetn),
    .dif     (app_if)
  );

  // After an apply with run still on, a new release needs run to go off first,
  // so the load is not lifted again by a lingering run command.
  always_comb begin
    st_nxt  = st_r;
    brk_nxt = brk_r;
    if (trip) begin
      // RQ10 immediate apply
      st_nxt  = brake_pkg::BRK_APPLIED;
      brk_nxt = 1'b0;
    end else if (!first_motor) begin
      // RQ11 other motors hold on
      st_nxt  = brake_pkg::BRK_APPLIED;
      brk_nxt = 1'b1;
    end else begin
      unique case (st_r)
        brake_pkg::BRK_APPLIED: begin
          // RQ1 release after delay
          if (rel_if.done) begin
            st_nxt = brake_pkg::BRK_RELEASED;
          end
        end
        brake_pkg::BRK_RELEASED: begin
          // RQ8 apply after delay
          if (app_if.done) begin
            st_nxt = run_cmd ? brake_pkg::BRK_WAIT_RUN_OFF : brake_pkg::BRK_APPLIED;
          end
        end
        brake_pkg::BRK_WAIT_RUN_OFF: begin
          if (!run_cmd) begin
            st_nxt = brake_pkg::BRK_APPLIED;
          end
        end
        default: st_nxt = brake_pkg::BRK_APPLIED;
      endcase
      brk_nxt = (st_nxt == brake_pkg::BRK_RELEASED);
    end
    // RQ6 terminal function routing
    for (int i = 0; i < N_TERM; i++) begin
      term_nxt[i] = (tsel_r[i] == brake_pkg::BRAKE_FUNC_CODE) && brk_nxt;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r   <= brake_pkg::BRK_APPLIED;
      brk_r  <= 1'b0;
      term_r <= '0;
    end else begin
      st_r   <= st_nxt;
      brk_r  <= brk_nxt;
      term_r <= term_nxt;
    end
  end

  assign brake_release_out = brk_r;
  assign terminal_out      = term_r;

endmodule
`default_nettype wire

//--- core/brake_pkg.sv
package brake_pkg;

  // Timing
  localparam int unsigned CLK_HZ      = 40_000_000;
  localparam int unsigned TICK_MS     = 100;
  localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;

  // Register byte offsets
  localparam logic [7:0] CTRL_OFS     = 8'h00;
  localparam logic [7:0] REL_CUR_OFS  = 8'h04;
  localparam logic [7:0] REL_FRQ_OFS  = 8'h08;
  localparam logic [7:0] REL_DLY_OFS  = 8'h0C;
  localparam logic [7:0] REL_TRQ_OFS  = 8'h10;
  localparam logic [7:0] APP_FRQ_OFS  = 8'h14;
  localparam logic [7:0] APP_DLY_OFS  = 8'h18;
  localparam logic [7:0] STOP_FRQ_OFS = 8'h1C;
  localparam logic [7:0] TSEL0_OFS    = 8'h20;
  localparam logic [7:0] TSEL1_OFS    = 8'h24;
  localparam logic [7:0] STATUS_OFS   = 8'h28;

  // Control register fields
  localparam int unsigned CTRL_VEC_BIT  = 0;
  localparam int unsigned CTRL_MOT_LSB  = 1;
  localparam int unsigned CTRL_DUTY_LSB = 3;
  localparam int unsigned CTRL_SPD_BIT  = 5;
  localparam int unsigned CTRL_W        = 6;

  // Field widths
  localparam int unsigned PCT_W = 9;
  localparam int unsigned FRQ_W = 8;
  localparam int unsigned DLY_W = 6;
  localparam int unsigned SEL_W = 8;
  localparam int unsigned QTY_W = 16;

  // Setting limits: percent, 0.1 Hz and 0.1 s units
  localparam logic [PCT_W-1:0] PCT_MAX  = 9'd300;
  localparam logic [FRQ_W-1:0] FRQ_MAX  = 8'd250;
  localparam logic [DLY_W-1:0] DLY_MAX  = 6'd50;
  localparam logic [6:0]       PCT_FULL = 7'd100;

  // Reset values
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] LVL_RST  = 32'h0000_0000;
  localparam logic [31:0] TSEL_RST = 32'h0000_0000;

  // Codes
  localparam logic [1:0]       MOTOR_FIRST     = 2'h0;
  localparam logic [1:0]       DUTY_MEDIUM     = 2'h1;
  localparam logic [1:0]       DUTY_LIGHT      = 2'h2;
  localparam logic [SEL_W-1:0] BRAKE_FUNC_CODE = 8'd57;

  typedef enum logic [1:0] {
    BRK_APPLIED,
    BRK_RELEASED,
    BRK_WAIT_RUN_OFF
  } brake_state_t;

endpackage

//--- core/delay_if.sv
`timescale 1ns/1ps
`default_nettype none
interface delay_if #(
  parameter int unsigned DW = 6
);
  logic          cond;
  logic [DW-1:0] delay;
  logic          done;
  logic          running;

  modport owner (output cond, output delay, input done, input running);
  modport timer (input cond, input delay, output done, output running);
endinterface
`default_nettype wire

//--- core/delay_timer.sv
`timescale 1ns/1ps
`default_nettype none
module delay_timer #(
  parameter int unsigned TICK_CYCLES = brake_pkg::TICK_CYCLES,
  parameter int unsigned DW          = 6
) (
  // Clock and reset
  input  wire logic hclk,
  input  wire logic hresetn,
  // Condition and result
  delay_if.timer    dif
);

  localparam int unsigned CW = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;

  if (TICK_CYCLES < 1) begin : g_chk
    $error("delay_timer needs TICK_CYCLES of at least 1");
  end

  logic [CW-1:0] cyc_r;
  logic [CW-1:0] cyc_nxt;
  logic [DW-1:0] cnt_r;
  logic [DW-1:0] cnt_nxt;

  // A private prescaler restarts with the condition, so the delay is exact
  // to the cycle rather than off by up to one tick.
  always_comb begin
    cyc_nxt = cyc_r;
    cnt_nxt = cnt_r;
    if (!dif.cond) begin
      cyc_nxt = '0;
      cnt_nxt = '0;
    end else if (cnt_r < dif.delay) begin
      if (cyc_r == CW'(TICK_CYCLES - 1)) begin
        cyc_nxt = '0;
        cnt_nxt = cnt_r + DW'(1);
      end else begin
        cyc_nxt = cyc_r + CW'(1);
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cyc_r <= '0;
      cnt_r <= '0;
    end else begin
      cyc_r <= cyc_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  assign dif.done    = dif.cond && (cnt_r >= dif.delay);
  assign dif.running = dif.cond && (cnt_r < dif.delay);

endmodule
`default_nettype wire

//--- core/_unused_placeholder_none.sv
`timescale 1ns/1ps

//--- verification/brake_model.sv
`timescale 1ns/1ps
`default_nettype none
module brake_model #(
  parameter int LAG = 3
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Brake coil command, 1 = release
  input  wire logic release_cmd,
  output logic      released
);
  logic [LAG-1:0] pipe_r;
  logic [LAG-1:0] pipe_nxt;
  // Shoe lifts LAG cycles after the coil; a short glitch still shows, only delayed
  always_comb begin
    pipe_nxt = {pipe_r[LAG-2:0], release_cmd};
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pipe_r <= '0;
    end else begin
      pipe_r <= pipe_nxt;
    end
  end
  assign released = pipe_r[LAG-1];
endmodule
`default_nettype wire

//--- verification/hoist_brake_signal_control_sva.sv
`timescale 1ns/1ps
`default_nettype none
module brake_sva #(
  parameter int unsigned N_TERM = 6
) (
  input wire logic              hclk,
  input wire logic              hresetn,
  input wire logic              hsel,
  input wire logic [31:0]       haddr,
  input wire logic [1:0]        htrans,
  input wire logic              hwrite,
  input wire logic              hready,
  input wire logic              hreadyout,
  input wire logic              hresp,
  input wire logic [31:0]       hrdata,
  input wire logic              alarm_stop,
  input wire logic              coast_stop_cmd,
  input wire logic              brake_release_out,
  input wire logic [N_TERM-1:0] terminal_out
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic rd_req;
  assign rd_req = hsel && hready && htrans[1] && !hwrite;

  a_alarm_apply: assert property (alarm_stop |=> !brake_release_out)
    else $error("alarm left brake released");
  a_coast_hold: assert property (coast_stop_cmd [*2] |-> !brake_release_out)
    else $error("coast stop left brake released");
  a_trip_no_rise: assert property ($rose(brake_release_out) |-> !$past(alarm_stop) && !$past(coast_stop_cmd))
    else $error("brake released during trip");
  a_term_follow: assert property (|terminal_out |-> brake_release_out)
    else $error("terminal high with brake applied");
  a_status_echo: assert property (rd_req && haddr[7:0] == brake_pkg::STATUS_OFS
    |=> hrdata[0] == $past(brake_release_out))
    else $error("status bit differs from brake output");
  a_unmapped_zero: assert property (rd_req && haddr[7:0] > brake_pkg::STATUS_OFS |=> hrdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_reset_low: assert property ($rose(hresetn) |-> !brake_release_out && terminal_out == '0)
    else $error("brake not applied after reset");
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus slave stalled or erred");

  c_release: cover property ($rose(brake_release_out));
  c_apply: cover property ($fell(brake_release_out));
  c_status: cover property (rd_req && haddr[7:0] == brake_pkg::STATUS_OFS);
endmodule

bind hoist_brake_signal_control brake_sva #(.N_TERM(N_TERM)) u_sva (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
  .alarm_stop(alarm_stop), .coast_stop_cmd(coast_stop_cmd),
  .brake_release_out(brake_release_out), .terminal_out(terminal_out)
);
`default_nettype wire

//--- verification/hoist_brake_signal_control_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module hoist_brake_signal_control_tb_top;
  localparam int TK = 4;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0000_0000;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic [15:0] cur = 16'h0000;
  logic [15:0] frq = 16'h0000;
  logic [15:0] trq = 16'h0000;
  logic [15:0] rsp = 16'h0000;
  logic [15:0] dsp = 16'h0000;
  logic        run = 1'b0;
  logic        alm = 1'b0;
  logic        cst = 1'b0;
  logic        brk;
  logic [5:0]  term;
  logic        held;
  int          bad_count = 0;
  int          n_checks = 0;

  always #12.5 hclk = ~hclk;

  hoist_brake_signal_control #(.TICK_CYCLES(TK)) dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .output_current(cur), .output_freq(frq), .torque_cmd(trq), .ref_speed(rsp),
    .det_speed(dsp), .run_cmd(run), .alarm_stop(alm), .coast_stop_cmd(cst),
    .brake_release_out(brk), .terminal_out(term)
  );
  // Terminal 1 carries the brake command
  brake_model u_brake (.clk(hclk), .rst_n(hresetn), .release_cmd(term[1]), .released(held));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr  <= {24'h00_0000, a};
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    q = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0000_0000, q);
    check(q, e);
  endtask

  task automatic drive(input logic [15:0] c, input logic [15:0] f, input logic [15:0] t);
    @(posedge hclk);
    cur <= c;
    frq <= f;
    trq <= t;
  endtask

  task automatic wait_brk(input logic v, input int lim, output int n);
    n = 0;
    while (brk !== v && n < lim) begin
      @(posedge hclk);
      #1;
      n++;
    end
  endtask

  // Quantities dropped first so the trip ends in the applied state
  task automatic trip(input bit coast);
    drive(16'h0000, 16'h0000, 16'h0000);
    if (coast) cst <= 1'b1;
    else alm <= 1'b1;
    repeat (2) @(posedge hclk);
    alm <= 1'b0;
    cst <= 1'b0;
    #1;
    check(brk, 1'b0);
  endtask

  task automatic rel(input logic [15:0] c, input logic [15:0] f, input logic [15:0] t, input int d, input bit yes);
    int n;
    drive(c, f, t);
    wait_brk(1'b1, d*TK+8, n);
    if (yes) check(n >= d*TK && n <= d*TK+3, 1'b1);
    else check(brk, 1'b0);
  endtask

  task automatic s_regs();
    logic [7:0]  a [5] = '{8'h04, 8'h08, 8'h0C, 8'h10, 8'h40};
    logic [31:0] d [5] = '{32'h0000_01F4, 32'h0000_012C, 32'h0000_003C, 32'h0000_01FF, 32'h0000_0055};
    logic [31:0] e [5] = '{32'h0000_012C, 32'h0000_00FA, 32'h0000_0032, 32'h0000_012C, 32'h0000_0000};
    rd_chk(brake_pkg::CTRL_OFS, brake_pkg::CTRL_RST);
    rd_chk(brake_pkg::STATUS_OFS, 32'h0000_0000);
    foreach (a[i]) begin
      wr(a[i], d[i]);
      rd_chk(a[i], e[i]);
    end
  endtask

  task automatic s_current();
    logic [31:0] q;
    trip(1'b0);
    rel(16'd50, 16'd0, 16'd0, 2, 1'b0);
    rel(16'd51, 16'd0, 16'd0, 2, 1'b1);
    check(term, 6'h02);
    repeat (4) @(posedge hclk);
    #1;
    check(held, 1'b1);
    bus(1'b0, brake_pkg::STATUS_OFS, 32'h0000_0000, q);
    check(q[0], 1'b1);
    trip(1'b1);
    check(term, 6'h00);
  endtask

  task automatic s_restart();
    trip(1'b0);
    drive(16'd51, 16'd0, 16'd0);
    repeat (6) @(posedge hclk);
    cur <= 16'd0;
    rel(16'd51, 16'd0, 16'd0, 2, 1'b1);
    wr(brake_pkg::REL_DLY_OFS, 32'h0000_0000);
    trip(1'b0);
    rel(16'd51, 16'd0, 16'd0, 0, 1'b1);
    wr(brake_pkg::REL_DLY_OFS, 32'h0000_0002);
  endtask

  task automatic s_duty();
    wr(brake_pkg::CTRL_OFS, 32'h0000_0008);
    trip(1'b0);
    rel(16'd60, 16'd0, 16'd0, 2, 1'b0);
    rel(16'd61, 16'd0, 16'd0, 2, 1'b1);
    wr(brake_pkg::CTRL_OFS, 32'h0000_0010);
    trip(1'b0);
    rel(16'd75, 16'd0, 16'd0, 2, 1'b0);
    rel(16'd76, 16'd0, 16'd0, 2, 1'b1);
    wr(brake_pkg::CTRL_OFS, 32'h0000_0000);
  endtask

  task automatic s_modes();
    trip(1'b0);
    rel(16'd0, 16'd0, 16'd200, 2, 1'b0);
    rel(16'd0, 16'd101, 16'd0, 2, 1'b1);
    wr(brake_pkg::CTRL_OFS, 32'h0000_0001);
    trip(1'b0);
    rel(16'd0, 16'd200, 16'd0, 2, 1'b0);
    rel(16'd0, 16'd0, 16'd51, 2, 1'b1);
    wr(brake_pkg::CTRL_OFS, 32'h0000_0000);
  endtask

  task automatic s_apply();
    int n;
    trip(1'b0);
    rel(16'd51, 16'd0, 16'd0, 2, 1'b1);
    wr(brake_pkg::APP_DLY_OFS, 32'h0000_0001);
    // Run goes on first, else the apply level acts as soon as it lands
    run <= 1'b1;
    wr(brake_pkg::APP_FRQ_OFS, 32'h0000_0032);
    drive(16'd0, 16'd10, 16'd0);
    wait_brk(1'b0, TK+8, n);
    check(brk, 1'b1);
    @(posedge hclk);
    run <= 1'b0;
    wait_brk(1'b0, TK+8, n);
    check(n >= TK && n <= TK+3, 1'b1);
    wr(brake_pkg::APP_FRQ_OFS, 32'h0000_0000);
    // Vector mode, reference speed selected
    wr(brake_pkg::CTRL_OFS, 32'h0000_0021);
    wr(brake_pkg::STOP_FRQ_OFS, 32'h0000_001E);
    rsp <= 16'd100;
    dsp <= 16'd10;
    trip(1'b0);
    rel(16'd0, 16'd0, 16'd51, 2, 1'b1);
    wait_brk(1'b0, TK+8, n);
    check(brk, 1'b1);
    @(posedge hclk);
    run <= 1'b1;
    rsp <= 16'd10;
    wait_brk(1'b0, TK+8, n);
    check(n >= TK && n <= TK+3, 1'b1);
    // Applied with run still on: torque above level must not release again
    wait_brk(1'b1, 2*TK+8, n);
    check(brk, 1'b0);
    @(posedge hclk);
    run <= 1'b0;
    wait_brk(1'b1, 2*TK+8, n);
    check(n >= 2*TK && n <= 2*TK+3, 1'b1);
    wr(brake_pkg::STOP_FRQ_OFS, 32'h0000_0000);
    wr(brake_pkg::CTRL_OFS, 32'h0000_0000);
  endtask

  task automatic s_motor();
    int n;
    trip(1'b0);
    wr(brake_pkg::CTRL_OFS, 32'h0000_0002);
    wait_brk(1'b1, 8, n);
    check(brk, 1'b1);
    trip(1'b0);
    wr(brake_pkg::CTRL_OFS, 32'h0000_0000);
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Whole run needs a few hundred cycles
  initial begin
    repeat (20000) @(posedge hclk);
    bad_count++;
    complete_run();
  end

  initial begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    s_regs();
    wr(brake_pkg::TSEL0_OFS, 32'h0000_3900);
    wr(brake_pkg::REL_CUR_OFS, 32'h0000_0032);
    wr(brake_pkg::REL_FRQ_OFS, 32'h0000_0064);
    wr(brake_pkg::REL_DLY_OFS, 32'h0000_0002);
    wr(brake_pkg::REL_TRQ_OFS, 32'h0000_0032);
    s_current();
    s_restart();
    s_duty();
    s_modes();
    s_apply();
    s_motor();
    complete_run();
  end
endmodule
`default_nettype wire
